// ### inc/dfm_pkg.sv
// dfm_pkg: constants and carriers for the format, filter and mode register bank
// assumes: 8-bit registers reached over a four-wire serial control port
`default_nettype none

package dfm_pkg;

  // ----------------------------------------
  // register offsets on the control port
  // ----------------------------------------
  localparam logic [6:0] AUDIO_FORMAT_CONTROL_OFS   = 7'h05;
  localparam logic [6:0] FILTER_CONTROL_OFS         = 7'h06;
  localparam logic [6:0] OPERATING_MODE_CONTROL_OFS = 7'h07;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] AUDIO_FORMAT_CONTROL_RST   = 8'h0A; // 24-bit, i2s
  localparam logic [7:0] FILTER_CONTROL_RST         = 8'h00;
  localparam logic [7:0] OPERATING_MODE_CONTROL_RST = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int IWL_LSB  = 0;   // input word length, 2 bits
  localparam int FMT_LSB  = 2;   // framing format, 2 bits
  localparam int LRP_BIT  = 4;   // frame clock polarity / dsp variant
  localparam int BCP_BIT  = 5;   // bit clock polarity
  localparam int REV_BIT  = 6;   // output phase invert
  localparam int PWD_BIT  = 7;   // power down
  localparam int PFIL_LSB = 0;   // pcm filter, 3 bits
  localparam int DFIL_LSB = 3;   // dsd comp filter, 2 bits
  localparam int DEEM_LSB = 5;   // de-emphasis, 2 bits
  localparam int ZFHI_BIT = 7;   // zero flag force high
  localparam int MODE_LSB = 0;   // operating mode, 2 bits
  localparam int RAT_LSB  = 2;   // clock ratio, 3 bits
  localparam int BAND_LSB = 5;   // rate band, 2 bits
  localparam int BYP_BIT  = 7;   // eight fs bypass

  // ----------------------------------------
  // codes and limits
  // ----------------------------------------
  localparam logic [1:0] FMT_DSP      = 2'h3;
  localparam logic [1:0] MODE_PCM     = 2'h0;
  localparam logic [1:0] MODE_UNUSED  = 2'h3;
  localparam logic [1:0] BAND_LOW     = 2'h0;
  localparam logic [1:0] BAND_UNUSED  = 2'h3;
  localparam logic [2:0] PFIL_MAX     = 3'h4;
  localparam logic [2:0] PFIL_FIRST   = 3'h0;
  localparam logic [2:0] RATIO_MAX    = 3'h6;
  localparam logic [2:0] RATIO_AUTO   = 3'h0;

  // ----------------------------------------
  // serial frame timing, in sclk edges
  // ----------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10; // read flag, 7 addr, 8 data
  localparam logic [4:0] HEAD_BITS  = 5'h08; // read flag plus address

  // register selector
  typedef enum logic [1:0] {
    DFM_SEL_NONE = 2'b00,
    DFM_SEL_FMT  = 2'b01,
    DFM_SEL_FLT  = 2'b10,
    DFM_SEL_MODE = 2'b11
  } dfm_sel_e;

  // decoded controls toward the datapath
  typedef struct packed {
    logic [1:0] input_word_length;
    logic [1:0] framing_format;
    logic       frame_clock_polarity;
    logic       dsp_variant_b;
    logic       bit_clock_polarity;
    logic       output_phase_invert;
    logic       power_down;
    logic [2:0] pcm_filter_select;
    logic [1:0] dsd_comp_filter_select;
    logic [1:0] deemphasis_select;
    logic [1:0] operating_mode_select;
    logic [2:0] clock_ratio_select;
    logic [1:0] rate_band_select;
    logic       eight_fs_bypass;
  } dfm_ctl_s;

endpackage

`default_nettype wire

// ### logic/dfm_regs.sv
// dfm_regs: format, filter and mode control registers behind the serial port
// assumes: cs_n, sclk, sdi arrive asynchronously from the host pins;
// zero_detect comes from datapath logic on the same clock
`default_nettype none

module dfm_regs (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          cs_n,         // serial frame select, low active
  input  wire logic          sclk,         // serial bit clock
  input  wire logic          sdi,          // serial data in
  input  wire logic          zero_detect,  // datapath zero detection
  output var  logic          sdo,          // serial readback data
  output var  logic          sdo_oe,       // high while driving sdo
  output var  dfm_pkg::dfm_ctl_s ctl,      // decoded controls
  output var  logic          zero_flag_out // zero flag pin level
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // shared by write commit and readback
  function automatic dfm_pkg::dfm_sel_e sel_of(input logic [6:0] a);
    case (a)
      dfm_pkg::AUDIO_FORMAT_CONTROL_OFS:   sel_of = dfm_pkg::DFM_SEL_FMT;
      dfm_pkg::FILTER_CONTROL_OFS:         sel_of = dfm_pkg::DFM_SEL_FLT;
      dfm_pkg::OPERATING_MODE_CONTROL_OFS: sel_of = dfm_pkg::DFM_SEL_MODE;
      default:                             sel_of = dfm_pkg::DFM_SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // order {cs_n, sclk, sdi}
  logic [2:0] s1_q, s2_q, s3_q; // three stage chain
  logic [2:0] flt_q, flt_d;     // agreed level
  logic [2:0] prv_q;            // agreed level, one clock older

  // a one-clock glitch on a pin never reaches the shifter, at the
  // cost of one extra clock of lag on every pin
  // accept a change only once stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end

  // chain and filter registers; idle levels are cs high, sclk low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q  <= 3'h4;
      s2_q  <= 3'h4;
      s3_q  <= 3'h4;
      flt_q <= 3'h4;
      prv_q <= 3'h4;
    end else begin
      s1_q  <= {cs_n, sclk, sdi};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
      prv_q <= flt_q;
    end
  end

  logic cs_act;   // frame open
  logic cs_end;   // frame just closed
  logic sck_rise; // sample edge
  logic sck_fall; // launch edge
  assign cs_act   = ~flt_q[2];
  assign cs_end   = flt_q[2] & ~prv_q[2];
  assign sck_rise = flt_q[1] & ~prv_q[1];
  assign sck_fall = ~flt_q[1] & prv_q[1];

  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  logic [15:0] sh_q, sh_d;   // incoming bits, msb first
  logic [4:0]  cnt_q, cnt_d; // bits taken this frame
  logic [7:0]  rd_q, rd_d;   // outgoing readback bits
  logic        sdo_d, oe_d;
  logic        wr_go;        // commit a complete write frame
  logic [7:0]  rd_val;       // readback mux
  // bank storage lives here because the readback mux reads it
  logic [7:0]  fmt_q, fmt_d;     // audio_format_control
  logic [7:0]  flt_r_q, flt_r_d; // filter_control
  logic [7:0]  mode_q, mode_d;   // operating_mode_control

  // readback of the addressed register, zero elsewhere
  always_comb begin
    case (sel_of(sh_q[6:0]))
      dfm_pkg::DFM_SEL_FMT:  rd_val = fmt_q;
      dfm_pkg::DFM_SEL_FLT:  rd_val = flt_r_q;
      dfm_pkg::DFM_SEL_MODE: rd_val = mode_q;
      default:               rd_val = 8'h00;
    endcase
  end

  // shift in on rising sclk, shift out on falling sclk
  always_comb begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    rd_d  = rd_q;
    sdo_d = sdo;
    oe_d  = sdo_oe;
    wr_go = 1'b0;
    if (!cs_act) begin
      // commit only on the closing edge of cs, so a host can abort a
      // frame at any point by raising cs early
      // a short or long frame is dropped whole
      wr_go = cs_end && (cnt_q == dfm_pkg::FRAME_BITS) && !sh_q[15];
      cnt_d = 5'h00;
      oe_d  = 1'b0;
      sdo_d = 1'b0;
    end else if (sck_rise) begin
      sh_d = {sh_q[14:0], flt_q[0]};
      // stop counting past a full frame so overruns never commit
      if (cnt_q <= dfm_pkg::FRAME_BITS) begin
        cnt_d = cnt_q + 5'h01;
      end
    end else if (sck_fall) begin
      if (cnt_q == dfm_pkg::HEAD_BITS && sh_q[7]) begin
        // launching on the fall gives the host a whole low phase to
        // see the bit settle before its next rising edge
        // header done, read flag set: load and launch msb
        rd_d  = rd_val;
        sdo_d = rd_val[7];
        oe_d  = 1'b1;
      end else if (oe_d) begin
        rd_d  = {rd_q[6:0], 1'b0};
        sdo_d = rd_q[6];
      end
    end
  end

  // shifter registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_q   <= 16'h0000;
      cnt_q  <= 5'h00;
      rd_q   <= 8'h00;
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      rd_q   <= rd_d;
      sdo    <= sdo_d;
      sdo_oe <= oe_d;
    end
  end

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  // stored bytes are declared with the shifter above; the decode
  // below, not the store, keeps unused codes away from the datapath

  // every bit is stored as written, unused codes included
  always_comb begin
    fmt_d   = fmt_q;
    flt_r_d = flt_r_q;
    mode_d  = mode_q;
    if (wr_go) begin
      case (sel_of(sh_q[14:8]))
        dfm_pkg::DFM_SEL_FMT:  fmt_d   = sh_q[7:0];
        dfm_pkg::DFM_SEL_FLT:  flt_r_d = sh_q[7:0];
        dfm_pkg::DFM_SEL_MODE: mode_d  = sh_q[7:0];
        default:               fmt_d   = fmt_q;     // unmapped: ignored
      endcase
    end
  end

  // bank registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fmt_q   <= dfm_pkg::AUDIO_FORMAT_CONTROL_RST;
      flt_r_q <= dfm_pkg::FILTER_CONTROL_RST;
      mode_q  <= dfm_pkg::OPERATING_MODE_CONTROL_RST;
    end else begin
      fmt_q   <= fmt_d;
      flt_r_q <= flt_r_d;
      mode_q  <= mode_d;
    end
  end

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  dfm_pkg::dfm_ctl_s ctl_d;
  logic              zf_d;

  // unused codes fall back to the default setting
  always_comb begin
    ctl_d.input_word_length  = fmt_q[dfm_pkg::IWL_LSB +: 2];
    ctl_d.framing_format     = fmt_q[dfm_pkg::FMT_LSB +: 2];
    // same bit, meaning depends on framing
    ctl_d.frame_clock_polarity = fmt_q[dfm_pkg::LRP_BIT] &&
                                 (ctl_d.framing_format != dfm_pkg::FMT_DSP);
    ctl_d.dsp_variant_b        = fmt_q[dfm_pkg::LRP_BIT] &&
                                 (ctl_d.framing_format == dfm_pkg::FMT_DSP);
    ctl_d.bit_clock_polarity  = fmt_q[dfm_pkg::BCP_BIT];
    ctl_d.output_phase_invert = fmt_q[dfm_pkg::REV_BIT];
    ctl_d.power_down          = fmt_q[dfm_pkg::PWD_BIT];
    ctl_d.pcm_filter_select = flt_r_q[dfm_pkg::PFIL_LSB +: 3];
    if (ctl_d.pcm_filter_select > dfm_pkg::PFIL_MAX) begin
      ctl_d.pcm_filter_select = dfm_pkg::PFIL_FIRST;
    end
    ctl_d.dsd_comp_filter_select = flt_r_q[dfm_pkg::DFIL_LSB +: 2];
    ctl_d.deemphasis_select      = flt_r_q[dfm_pkg::DEEM_LSB +: 2];
    ctl_d.operating_mode_select  = mode_q[dfm_pkg::MODE_LSB +: 2];
    if (ctl_d.operating_mode_select == dfm_pkg::MODE_UNUSED) begin
      ctl_d.operating_mode_select = dfm_pkg::MODE_PCM;
    end
    ctl_d.clock_ratio_select = mode_q[dfm_pkg::RAT_LSB +: 3];
    if (ctl_d.clock_ratio_select > dfm_pkg::RATIO_MAX) begin
      ctl_d.clock_ratio_select = dfm_pkg::RATIO_AUTO;
    end
    ctl_d.rate_band_select = mode_q[dfm_pkg::BAND_LSB +: 2];
    if (ctl_d.rate_band_select == dfm_pkg::BAND_UNUSED) begin
      ctl_d.rate_band_select = dfm_pkg::BAND_LOW;
    end
    ctl_d.eight_fs_bypass = mode_q[dfm_pkg::BYP_BIT];
    // force wins over the detector
    zf_d = flt_r_q[dfm_pkg::ZFHI_BIT] | zero_detect;
  end

  // output flops, so the datapath sees clean levels
  // one clock of extra lag buys glitch-free control levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl           <= '0;
      zero_flag_out <= 1'b0;
    end else begin
      ctl           <= ctl_d;
      zero_flag_out <= zf_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // write path: each register takes exactly the committed byte
  a_write_commit: assert property (wr_go && sh_q[14:8] == dfm_pkg::AUDIO_FORMAT_CONTROL_OFS
    |=> fmt_q == $past(sh_q[7:0])) else $error("format write lost");
  a_filter_commit: assert property (wr_go && sh_q[14:8] == dfm_pkg::FILTER_CONTROL_OFS
    |=> flt_r_q == $past(sh_q[7:0])) else $error("filter write lost");
  a_mode_commit: assert property (wr_go && sh_q[14:8] == dfm_pkg::OPERATING_MODE_CONTROL_OFS
    |=> mode_q == $past(sh_q[7:0])) else $error("mode write lost");
  // refused frames, reads included, leave the whole bank untouched
  a_frame_refused: assert property (cs_end && (cnt_q != dfm_pkg::FRAME_BITS || sh_q[15])
    |=> $stable(fmt_q) && $stable(flt_r_q) && $stable(mode_q))
    else $error("refused frame changed a register");

  // control outputs trail the bank by exactly one clock
  a_word_follow: assert property (##1 $changed(fmt_q) |=>
    ctl.input_word_length == $past(fmt_q[1:0])) else $error("word length stale");
  a_frame_pol: assert property (##1 1'b1 |-> ctl.frame_clock_polarity ==
    ($past(fmt_q[dfm_pkg::LRP_BIT]) && $past(fmt_q[dfm_pkg::FMT_LSB +: 2]) != dfm_pkg::FMT_DSP))
    else $error("frame polarity misdecoded");
  a_dsp_variant: assert property (ctl.dsp_variant_b |-> ctl.framing_format == dfm_pkg::FMT_DSP
    && !ctl.frame_clock_polarity) else $error("dsp variant misdecoded");
  a_phase_follow: assert property (##1 1'b1 |-> ctl.output_phase_invert == $past(fmt_q[dfm_pkg::REV_BIT]))
    else $error("phase invert stale");
  a_power_down: assert property (##1 1'b1 |-> ctl.power_down == $past(fmt_q[dfm_pkg::PWD_BIT]))
    else $error("power down stale");
  a_dsd_follow: assert property (##1 1'b1 |->
    ctl.dsd_comp_filter_select == $past(flt_r_q[dfm_pkg::DFIL_LSB +: 2])) else $error("dsd filter stale");
  a_deemph_follow: assert property (##1 1'b1 |->
    ctl.deemphasis_select == $past(flt_r_q[dfm_pkg::DEEM_LSB +: 2])) else $error("de-emphasis stale");
  a_zero_force: assert property (flt_r_q[dfm_pkg::ZFHI_BIT] |=> zero_flag_out)
    else $error("zero flag not forced");
  a_zero_follow: assert property (!flt_r_q[dfm_pkg::ZFHI_BIT] |=> zero_flag_out == $past(zero_detect))
    else $error("zero flag not following detector");
  a_mode_safe: assert property (ctl.operating_mode_select != dfm_pkg::MODE_UNUSED
    && ctl.rate_band_select != dfm_pkg::BAND_UNUSED) else $error("unused mode out");
  a_ratio_safe: assert property (ctl.clock_ratio_select <= dfm_pkg::RATIO_MAX
    && ctl.pcm_filter_select <= dfm_pkg::PFIL_MAX) else $error("unused code out");
  a_bypass_follow: assert property (##1 1'b1 |-> ctl.eight_fs_bypass == $past(mode_q[dfm_pkg::BYP_BIT]))
    else $error("bypass stale");
  a_sdo_frame: assert property (sdo_oe |-> $past(cs_act))
    else $error("sdo driven outside frame");

endmodule

`default_nettype wire

// ### sim/dfm_host.sv
// dfm_host: serial control host model for the format, filter and mode bank
// assumes: sdo is valid from the 8th sclk fall of a read frame while sdo_oe is high
`default_nettype none

module dfm_host (
  input  wire logic clock,  // system clock, used only for pacing
  output var  logic cs_n,   // frame select, low active
  output var  logic sclk,   // serial clock, still between frames
  output var  logic sdi,    // command and data bits
  input  wire logic sdo,    // readback bit from the device
  input  wire logic sdo_oe  // device drives sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels before any frame
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // ----------------------------------------
  // one frame, msb first, 8 clocks per sclk phase
  // ----------------------------------------
  // nbits other than 16 makes a malformed frame on purpose
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                      input int nbits, output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, adr, wd};
    rdat = 8'h00;
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = word[15 - i];
      repeat (8) @(negedge clock);
      // undriven sdo reads as unknown so it can never match
      if (i >= 8) rdat[15 - i] = sdo_oe ? sdo : 1'bx;
      sclk = 1'b1;
      repeat (8) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clock);
    cs_n = 1'b1;
    // flip sdi so no stale level lingers after the frame
    sdi = ~sdi;
    // gap covers the synchroniser and commit lag
    repeat (12) @(negedge clock);
  endtask
endmodule

`default_nettype wire

// ### sim/dfm_regs_tb_top.sv
// dfm_regs_tb_top: self-checking bench for the format, filter and mode bank
// assumes: dfm_host drives the serial port; zero_detect is driven here
`default_nettype none

module dfm_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  logic              clock, rst, cs_n, sclk, sdi, zero_detect;
  logic              sdo, sdo_oe, zero_flag_out;
  dfm_pkg::dfm_ctl_s ctl;           // decoded controls seen
  int                miscompares = 0;
  int                checks_done = 0;
  // values that reach every code of every field except pcm filter codes 1 and 6
  logic [7:0]        vals [11] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h03, 8'h04,
                                   8'h1C, 8'h6B, 8'h0C, 8'h18, 8'h10};

  dfm_regs uut (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
                .zero_detect(zero_detect), .sdo(sdo), .sdo_oe(sdo_oe), .ctl(ctl),
                .zero_flag_out(zero_flag_out));
  dfm_host host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
                 .sdo_oe(sdo_oe));

  // 100 MHz clock
  always #5 clock = ~clock;

  // ----------------------------------------
  // compare, verdict and register access
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    host.xfer(1'b0, a, d, 16, junk);
  endtask

  // data bits sent in a read frame are don't-care, so send a pattern
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer(1'b1, a, 8'h5A, 16, d);
  endtask

  // defaults after any reset, seen at readback and at the decoded outputs
  task automatic reset_chk();
    logic [7:0] r;
    rd(dfm_pkg::AUDIO_FORMAT_CONTROL_OFS, r);
    chk("fmt_rst", r, 8'h0A);
    chk("wl_rst", 8'(ctl.input_word_length), 8'h02);
    chk("framing_rst", 8'(ctl.framing_format), 8'h02);
    rd(dfm_pkg::FILTER_CONTROL_OFS, r);
    chk("flt_rst", r, 8'h00);
    rd(dfm_pkg::OPERATING_MODE_CONTROL_OFS, r);
    chk("mode_rst", r, 8'h00);
    chk("zero_flag_out_rst", 8'(zero_flag_out), 8'(zero_detect));
  endtask

  // write, read back, then check every decoded field of that register
  task automatic field_chk(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    wr(a, d);
    rd(a, r);
    chk("readback", r, d);
    if (a == dfm_pkg::AUDIO_FORMAT_CONTROL_OFS) begin
      chk("word_len", 8'(ctl.input_word_length), 8'(d[1:0]));
      chk("framing", 8'(ctl.framing_format), 8'(d[3:2]));
      chk("frame_pol", 8'(ctl.frame_clock_polarity), 8'(d[4] & (d[3:2] != 2'h3)));
      chk("dsp_b", 8'(ctl.dsp_variant_b), 8'(d[4] & (d[3:2] == 2'h3)));
      chk("bit_pol", 8'(ctl.bit_clock_polarity), 8'(d[5]));
      chk("phase", 8'(ctl.output_phase_invert), 8'(d[6]));
      chk("power_down", 8'(ctl.power_down), 8'(d[7]));
    end else if (a == dfm_pkg::FILTER_CONTROL_OFS) begin
      chk("pcm_filt", 8'(ctl.pcm_filter_select), d[2:0] > 3'h4 ? 8'h00 : 8'(d[2:0]));
      chk("dsd_filt", 8'(ctl.dsd_comp_filter_select), 8'(d[4:3]));
      chk("deemph", 8'(ctl.deemphasis_select), 8'(d[6:5]));
      chk("zero_flag_out", 8'(zero_flag_out), 8'(d[7] | zero_detect));
    end else begin
      chk("op_mode", 8'(ctl.operating_mode_select), d[1:0] == 2'h3 ? 8'h00 : 8'(d[1:0]));
      chk("ratio", 8'(ctl.clock_ratio_select), d[4:2] == 3'h7 ? 8'h00 : 8'(d[4:2]));
      chk("band", 8'(ctl.rate_band_select), d[6:5] == 2'h3 ? 8'h00 : 8'(d[6:5]));
      chk("bypass", 8'(ctl.eight_fs_bypass), 8'(d[7]));
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    clock       = 1'b0;
    rst         = 1'b1;
    zero_detect = 1'b0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    reset_chk();
    // every register through the value table, zero_detect alternating
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 11; i++) begin
        zero_detect = i[0];
        field_chk(dfm_pkg::AUDIO_FORMAT_CONTROL_OFS + 7'(k), vals[i]);
      end
    end
    // a frame one edge short must leave the register alone
    host.xfer(1'b0, dfm_pkg::FILTER_CONTROL_OFS, 8'h77, 15, r);
    rd(dfm_pkg::FILTER_CONTROL_OFS, r);
    chk("short_frame", r, vals[10]);
    // unmapped address holds nothing
    wr(7'h08, 8'hC3);
    rd(7'h08, r);
    chk("unmapped", r, 8'h00);
    // second reset in mid-run restores defaults
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    reset_chk();
    end_sim();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire
